// >>> tccr_timer.sv
// module: timer two counter with capture, reload, baud clocks and bus slave
`timescale 1ns/1ps
`default_nettype none
// How it works
// - overflow flag sets when the count overflows past ffff (to 0000 or the reload value); software clears.
// - hardware sets no overflow flag while either uart clock select is one.
// - writing one to the overflow flag sets it and requests an interrupt.
// - external flag sets when an enabled trigger fall captures or reloads.
// - external flag raises the interrupt request and stays until cleared.
// - writing one to the external flag sets it and requests an interrupt.
// - receive clock select picks this timer or the other timer overflows.
// - transmit clock select picks this timer or the other timer overflows.
// - trigger falls act only when enabled and outside baud mode.
// - count advances only while run control is one; with it zero, only trigger reloads and writes change it.
// - timer mode counts once per four or twelve crystal clocks.
// - baud mode outside counter mode counts once per two crystal clocks.
// - counter mode counts each falling edge of the event input.
// - capture select one captures the count on an enabled trigger fall.
// - capture select zero reloads on overflow and on enabled trigger fall.
// - either uart clock select forces reload on overflow, capture ignored.
// - prescale select zero divides by twelve, one divides by four.
// - capture copies count low and high bytes into the capture pair.
// - reload loads the counter from the software-loaded capture pair.
// - baud mode overflows are divided by sixteen before the uart.
module tccr_timer (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire tccr_pkg::tccr_axi_req_t s_axi_req,
  output var  tccr_pkg::tccr_axi_rsp_t s_axi_rsp,
  input  wire logic                   trigger_pin,
  input  wire logic                   event_count_input,
  input  wire logic                   other_timer_ovf,
  output var  logic                   uart_rx_clk,
  output var  logic                   uart_tx_clk,
  output var  logic                   timer_irq
);

  // registers
  logic [7:0]  control_r;
  logic [7:0]  clock_ctl_r;
  logic [15:0] capture_r;
  logic [15:0] count_r;
  logic [3:0]  pre_cnt_r;
  logic [3:0]  baud_cnt_r;
  logic        rx_clk_r;
  logic        tx_clk_r;
  logic        irq_r;

  // bus slave registers
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [7:0]  waddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  // next values
  logic [7:0]  control_nxt;
  logic [7:0]  clock_ctl_nxt;
  logic [15:0] capture_nxt;
  logic [15:0] count_nxt;
  logic [3:0]  pre_cnt_nxt;
  logic [3:0]  baud_cnt_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_nxt;

  // decoded control fields
  wire ovf_flag        = control_r[tccr_pkg::BIT_OVF_FLAG];
  wire ext_flag        = control_r[tccr_pkg::BIT_EXT_FLAG];
  wire rx_sel          = control_r[tccr_pkg::BIT_RX_SEL];
  wire tx_sel          = control_r[tccr_pkg::BIT_TX_SEL];
  wire ext_trigger_en  = control_r[tccr_pkg::BIT_EXT_EN];
  wire run_control     = control_r[tccr_pkg::BIT_RUN];
  wire ct_sel          = control_r[tccr_pkg::BIT_CT_SEL];
  wire cap_sel         = control_r[tccr_pkg::BIT_CAP_SEL];
  wire prescale_select = clock_ctl_r[tccr_pkg::BIT_PRESCALE];
  wire baud_mode       = rx_sel | tx_sel;

  // synchronised falling edges of the two pins
  logic trig_fall;
  logic event_fall;

  tccr_edge_sync u_trig_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (trigger_pin),
    .fall    (trig_fall)
  );

  tccr_edge_sync u_event_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (event_count_input),
    .fall    (event_fall)
  );

  // prescaler: crystal clocks per increment
  wire [3:0] pre_div = baud_mode       ? tccr_pkg::DIV_BAUD :
                       prescale_select ? tccr_pkg::DIV_FAST :
                                         tccr_pkg::DIV_SLOW;
  wire pre_tick = (pre_cnt_r >= pre_div - 4'h1);
  assign pre_cnt_nxt = (!run_control || pre_tick) ? 4'h0
                                                  : pre_cnt_r + 4'h1;

  // one increment of the count, gated by run control
  wire src_tick   = ct_sel ? event_fall : pre_tick;
  wire count_tick = run_control & src_tick;
  wire overflow   = count_tick & (count_r == tccr_pkg::COUNT_MAX);

  // trigger events and the actions they cause
  wire trig_ev = ext_trigger_en & ~baud_mode & trig_fall;
  wire cap_ev  = trig_ev & cap_sel & ~baud_mode;
  wire ovf_rld = overflow & (baud_mode | ~cap_sel);
  wire rld_ev  = ovf_rld | (trig_ev & ~cap_sel);
  wire ovf_set = overflow & ~baud_mode;

  // write handshake: both address and data held, answer not yet given
  wire wr_fire   = ~awready_r & ~wready_r & ~bvalid_r;
  wire hit_ctl_w = wr_fire & (waddr_r == tccr_pkg::ADDR_CONTROL);
  wire hit_clk_w = wr_fire & (waddr_r == tccr_pkg::ADDR_CLOCK_CTL);
  wire hit_cap_w = wr_fire & (waddr_r == tccr_pkg::ADDR_CAPTURE);
  wire hit_cnt_w = wr_fire & (waddr_r == tccr_pkg::ADDR_COUNT);
  wire wr_known  = hit_ctl_w | hit_clk_w | hit_cap_w | hit_cnt_w;

  // byte-lane merges of written data with current contents
  wire [7:0] ctl_wr = wstrb_r[0] ? wdata_r[7:0] : control_r;
  wire [7:0] clk_wr = wstrb_r[0] ? wdata_r[7:0] : clock_ctl_r;
  wire [15:0] cap_wr = {wstrb_r[1] ? wdata_r[15:8] : capture_r[15:8],
                        wstrb_r[0] ? wdata_r[7:0]  : capture_r[7:0]};
  wire [15:0] cnt_wr = {wstrb_r[1] ? wdata_r[15:8] : count_r[15:8],
                        wstrb_r[0] ? wdata_r[7:0]  : count_r[7:0]};

  // control register: written value, hardware sets win over clears
  wire [7:0] ctl_base = hit_ctl_w ? ctl_wr : control_r;
  always_comb begin
    control_nxt = ctl_base;
    if (ovf_set) begin
      control_nxt[tccr_pkg::BIT_OVF_FLAG] = 1'b1;
    end
    if (cap_ev || (trig_ev && !cap_sel)) begin
      control_nxt[tccr_pkg::BIT_EXT_FLAG] = 1'b1;
    end
  end

  assign clock_ctl_nxt = hit_clk_w ? clk_wr : clock_ctl_r;

  // capture pair: hardware capture wins over a software write
  assign capture_nxt = cap_ev    ? count_r :
                       hit_cap_w ? cap_wr  :
                                   capture_r;

  // count: software write, then reload, then increment
  assign count_nxt = hit_cnt_w  ? cnt_wr    :
                     rld_ev     ? capture_r :
                     count_tick ? count_r + 16'h0001 :
                                  count_r;

  // divide-by-sixteen of baud mode overflows
  wire baud_ovf   = overflow & baud_mode;
  wire baud_pulse = baud_ovf & (baud_cnt_r == tccr_pkg::BAUD_LAST);
  assign baud_cnt_nxt = !baud_mode ? 4'h0 :
                        baud_ovf   ? baud_cnt_r + 4'h1 :
                                     baud_cnt_r;

  // timer state registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_r   <= tccr_pkg::RST_CONTROL;
      clock_ctl_r <= tccr_pkg::RST_CLOCK_CTL;
      capture_r   <= tccr_pkg::RST_CAPTURE;
      count_r     <= tccr_pkg::RST_COUNT;
      pre_cnt_r   <= 4'h0;
      baud_cnt_r  <= 4'h0;
    end else begin
      control_r   <= control_nxt;
      clock_ctl_r <= clock_ctl_nxt;
      capture_r   <= capture_nxt;
      count_r     <= count_nxt;
      pre_cnt_r   <= pre_cnt_nxt;
      baud_cnt_r  <= baud_cnt_nxt;
    end
  end

  // uart clocks and interrupt request, each from a flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_clk_r <= 1'b0;
      tx_clk_r <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      rx_clk_r <= rx_sel ? baud_pulse : other_timer_ovf;
      tx_clk_r <= tx_sel ? baud_pulse : other_timer_ovf;
      irq_r    <= ovf_flag | ext_flag;
    end
  end

  // write channels: address and data taken in either order
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= tccr_pkg::RESP_OKAY;
      waddr_r   <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (awready_r && s_axi_req.awvalid) begin
        awready_r <= 1'b0;
        waddr_r   <= s_axi_req.awaddr;
      end
      if (wready_r && s_axi_req.wvalid) begin
        wready_r <= 1'b0;
        wdata_r  <= s_axi_req.wdata;
        wstrb_r  <= s_axi_req.wstrb;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_known ? tccr_pkg::RESP_OKAY : tccr_pkg::RESP_SLVERR;
      end
      if (bvalid_r && s_axi_req.bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // read data selection, unused upper bits read as zero
  wire [7:0] ar = s_axi_req.araddr;
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rresp_nxt = tccr_pkg::RESP_OKAY;
    if (ar == tccr_pkg::ADDR_CONTROL) begin
      rdata_nxt[7:0] = control_r;
    end else if (ar == tccr_pkg::ADDR_CLOCK_CTL) begin
      rdata_nxt[7:0] = clock_ctl_r;
    end else if (ar == tccr_pkg::ADDR_CAPTURE) begin
      rdata_nxt[15:0] = capture_r;
    end else if (ar == tccr_pkg::ADDR_COUNT) begin
      rdata_nxt[15:0] = count_r;
    end else begin
      rresp_nxt = tccr_pkg::RESP_SLVERR;
    end
  end

  // read channel: one read at a time
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= tccr_pkg::RESP_OKAY;
    end else if (arready_r && s_axi_req.arvalid) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end else if (rvalid_r && s_axi_req.rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // outputs
  assign s_axi_rsp.awready = awready_r;
  assign s_axi_rsp.wready  = wready_r;
  assign s_axi_rsp.bvalid  = bvalid_r;
  assign s_axi_rsp.bresp   = bresp_r;
  assign s_axi_rsp.arready = arready_r;
  assign s_axi_rsp.rvalid  = rvalid_r;
  assign s_axi_rsp.rdata   = rdata_r;
  assign s_axi_rsp.rresp   = rresp_r;
  assign uart_rx_clk       = rx_clk_r;
  assign uart_tx_clk       = tx_clk_r;
  assign timer_irq         = irq_r;

endmodule : tccr_timer
`default_nettype wire

// >>> tccr_pkg.sv
// package: register map, field layout, counts and bus carriers for timer two
package tccr_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CONTROL   = 8'hc8;
  localparam logic [7:0] ADDR_CLOCK_CTL = 8'hcc;
  localparam logic [7:0] ADDR_CAPTURE   = 8'hd0;
  localparam logic [7:0] ADDR_COUNT     = 8'hd4;

  // timer_two_control field positions
  localparam int BIT_OVF_FLAG  = 7;
  localparam int BIT_EXT_FLAG  = 6;
  localparam int BIT_RX_SEL    = 5;
  localparam int BIT_TX_SEL    = 4;
  localparam int BIT_EXT_EN    = 3;
  localparam int BIT_RUN       = 2;
  localparam int BIT_CT_SEL    = 1;
  localparam int BIT_CAP_SEL   = 0;
  // clock_control_register field position
  localparam int BIT_PRESCALE  = 5;

  // reset values
  localparam logic [7:0]  RST_CONTROL   = 8'h00;
  localparam logic [7:0]  RST_CLOCK_CTL = 8'h00;
  localparam logic [15:0] RST_CAPTURE   = 16'h0000;
  localparam logic [15:0] RST_COUNT     = 16'h0000;

  // crystal clocks per increment and baud divider
  localparam logic [3:0] DIV_SLOW  = 4'h0c;
  localparam logic [3:0] DIV_FAST  = 4'h04;
  localparam logic [3:0] DIV_BAUD  = 4'h02;
  localparam logic [3:0] BAUD_LAST = 4'h0f;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // master to slave signals of the register bus
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } tccr_axi_req_t;

  // slave to master signals of the register bus
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tccr_axi_rsp_t;

endpackage : tccr_pkg

// >>> tccr_edge_sync.sv
// module: two-stage pin synchroniser with falling edge detector
`timescale 1ns/1ps
`default_nettype none
module tccr_edge_sync (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output var  logic fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // pins idle high, so every stage resets high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // only the second stage and its delayed copy are compared
  assign fall = prev_r & ~sync_r;

endmodule : tccr_edge_sync
`default_nettype wire

// >>> tccr_props.sv
// checker: bus handshake, flag and uart clock properties of timer two
`timescale 1ns/1ps
`default_nettype none
module tccr_props (
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire tccr_pkg::tccr_axi_req_t s_axi_req,
  input wire tccr_pkg::tccr_axi_rsp_t s_axi_rsp,
  input wire logic                    trigger_pin,
  input wire logic                    event_count_input,
  input wire logic                    other_timer_ovf,
  input wire logic                    uart_rx_clk,
  input wire logic                    uart_tx_clk,
  input wire logic                    timer_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] sel_r;
  wire        aw_t = s_axi_req.awvalid && s_axi_rsp.awready;
  wire        w_t  = s_axi_req.wvalid && s_axi_rsp.wready;
  wire        ctl_w = aw_t && w_t &&
                      s_axi_req.awaddr == tccr_pkg::ADDR_CONTROL;
  // mirror of the two uart clock selects as software writes them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) sel_r <= 2'h0;
    else if (ctl_w) sel_r <= s_axi_req.wdata[5:4];
  end
  sequence wr_take_s;
    aw_t && w_t;
  endsequence
  sequence ar_take_s;
    s_axi_req.arvalid && s_axi_rsp.arready;
  endsequence
  b_stand_a: assert property (s_axi_rsp.bvalid && !s_axi_req.bready
    |=> s_axi_rsp.bvalid) else $error("write answer dropped early");
  r_stand_a: assert property (s_axi_rsp.rvalid && !s_axi_req.rready
    |=> s_axi_rsp.rvalid && $stable(s_axi_rsp.rdata))
    else $error("read answer dropped early");
  wr_answer_a: assert property (wr_take_s |-> ##[1:2] s_axi_rsp.bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (ar_take_s |=> s_axi_rsp.rvalid)
    else $error("read answer late");
  ready_back_a: assert property (s_axi_rsp.bvalid && s_axi_req.bready
    |=> s_axi_rsp.awready && s_axi_rsp.wready)
    else $error("write channels not ready again");
  bad_addr_a: assert property (ar_take_s ##0 s_axi_req.araddr[7:6] == 2'h0
    |=> s_axi_rsp.rresp == tccr_pkg::RESP_SLVERR && s_axi_rsp.rdata == 0)
    else $error("unmapped read not refused");
  irq_hold_a: assert property ($fell(timer_irq)
    |-> $past(s_axi_rsp.bvalid) || $past(s_axi_rsp.bvalid, 2))
    else $error("interrupt dropped without a write");
  baud_irq_a: assert property ($rose(timer_irq) && (|sel_r)
    |-> $past(s_axi_rsp.bvalid) || $past(s_axi_rsp.bvalid, 2))
    else $error("flag set by hardware in baud mode");
  rx_other_a: assert property (!sel_r[1] && other_timer_ovf
    |=> uart_rx_clk) else $error("receive clock missed other timer");
  tx_other_a: assert property (!sel_r[0] && other_timer_ovf
    |=> uart_tx_clk) else $error("transmit clock missed other timer");
endmodule : tccr_props
bind tccr_timer tccr_props u_tccr_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_req(s_axi_req),
  .s_axi_rsp(s_axi_rsp), .trigger_pin(trigger_pin),
  .event_count_input(event_count_input),
  .other_timer_ovf(other_timer_ovf), .uart_rx_clk(uart_rx_clk),
  .uart_tx_clk(uart_tx_clk), .timer_irq(timer_irq));
`default_nettype wire

// >>> tccr_pins.sv
// partner: trigger and event pin drivers, both idle high
`timescale 1ns/1ps
`default_nettype none
module tccr_pins (
  input  wire logic ref_clk,
  output var  logic trigger_pin,
  output var  logic event_count_input
);
  // pins rest high between events
  initial begin
    trigger_pin = 1'b1;
    event_count_input = 1'b1;
  end
  // one trigger fall, held past the synchroniser delay
  task automatic trigger_fall;
    trigger_pin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    trigger_pin <= 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask : trigger_fall
  // one event fall, wide enough to be sampled twice
  task automatic event_fall;
    event_count_input <= 1'b0;
    repeat (3) @(posedge ref_clk);
    event_count_input <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : event_fall
endmodule : tccr_pins
`default_nettype wire

// >>> tb_timer2_control_capture_reload.sv
// testbench: register bus driven checks of timer two
`timescale 1ns/1ps
`default_nettype none
module tb_timer2_control_capture_reload;
  localparam logic [7:0] A_CTL = tccr_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_CLK = tccr_pkg::ADDR_CLOCK_CTL;
  localparam logic [7:0] A_CAP = tccr_pkg::ADDR_CAPTURE;
  localparam logic [7:0] A_CNT = tccr_pkg::ADDR_COUNT;
  logic ref_clk = 1'b0;
  logic rst_n;
  logic ovf;
  tccr_pkg::tccr_axi_req_t req;
  tccr_pkg::tccr_axi_rsp_t rsp;
  wire logic trig, evt, rx, tx, irq;
  logic [31:0] v, seed;
  logic [15:0] r;
  logic [1:0]  resp_s;
  int mismatches = 0, checks_done = 0, nrx = 0, ntx = 0, k, a0, b0;
  tccr_timer u_tccr_timer (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_req(req), .s_axi_rsp(rsp), .trigger_pin(trig),
    .event_count_input(evt), .other_timer_ovf(ovf),
    .uart_rx_clk(rx), .uart_tx_clk(tx), .timer_irq(irq));
  tccr_pins u_tccr_pins (.ref_clk(ref_clk), .trigger_pin(trig),
    .event_count_input(evt));
  always #20 ref_clk = ~ref_clk;
  // count uart clock pulses
  always @(posedge ref_clk) begin
    nrx <= nrx + int'(rx === 1'b1);
    ntx <= ntx + int'(tx === 1'b1);
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // each of address and data is released at the edge that takes it
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hf;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (!aw_ok && rsp.awready) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_ok && rsp.wready) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    req.bready <= 1'b1;
    @(posedge ref_clk);
    while (!rsp.bvalid) @(posedge ref_clk);
    resp_s = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    req.arvalid <= 1'b1; req.araddr <= a;
    @(posedge ref_clk);
    while (!rsp.arready) @(posedge ref_clk);
    req.arvalid <= 1'b0;
    req.rready <= 1'b1;
    @(posedge ref_clk);
    while (!rsp.rvalid) @(posedge ref_clk);
    v = rsp.rdata; resp_s = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
    rd(a);
    chk(nm, v, e);
  endtask : rchk
  // count after k ticks from s, reloading c on each wrap
  function automatic logic [15:0] after(logic [15:0] s, int k, logic [15:0] c);
    for (int i = 0; i < k; i++) s = (s == 16'hffff) ? c : s + 16'h0001;
    return s;
  endfunction : after
  // run so that exactly k ticks of period div fall inside the span
  task automatic span(logic [7:0] ctl, int div, int k, logic [15:0] s);
    wr(A_CNT, {16'h0, s});
    wr(A_CTL, {24'h0, ctl | 8'h04});
    repeat (div * k + div / 2 - 5) @(posedge ref_clk);
    rd(A_CTL);
    wr(A_CTL, {24'h0, ctl | (v[7:0] & 8'hc0)}); // keep flags set meanwhile
  endtask : span
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // watchdog against a hung handshake
  initial begin
    #(40 * 40000);
    mismatches++;
    results();
  end
  // main sequence
  initial begin
    seed = $urandom(19);
    req = '0; ovf = 1'b0; rst_n = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rchk("reset ctl", A_CTL, {24'h0, tccr_pkg::RST_CONTROL});
    rchk("reset clk", A_CLK, {24'h0, tccr_pkg::RST_CLOCK_CTL});
    rchk("reset cap", A_CAP, {16'h0, tccr_pkg::RST_CAPTURE});
    rchk("reset cnt", A_CNT, {16'h0, tccr_pkg::RST_COUNT});
    rchk("unmapped rd", 8'h10, 32'h0);
    chk("rresp", {30'h0, resp_s}, {30'h0, tccr_pkg::RESP_SLVERR});
    wr(8'h10, 32'hff);
    chk("bresp", {30'h0, resp_s}, {30'h0, tccr_pkg::RESP_SLVERR});
    for (int f = 6; f < 8; f++) begin
      wr(A_CTL, 32'h1 << f);
      repeat (2) @(posedge ref_clk);
      chk("irq set", {31'h0, irq}, 32'h1);
      rchk("flag", A_CTL, 32'h1 << f);
      wr(A_CTL, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk("irq clr", {31'h0, irq}, 32'h0);
    end
    for (int m = 0; m < 3; m++) begin
      k = $urandom_range(10, 3);
      wr(A_CLK, (m == 1) ? 32'h20 : 32'h0);
      span((m == 2) ? 8'h30 : 8'h00, (m == 0) ? 12 : (m == 1) ? 4 : 2, k, 16'h0);
      repeat (k) @(posedge ref_clk);
      rchk("ticks", A_CNT, k);
    end
    wr(A_CLK, 32'h20);
    wr(A_CAP, 32'h5a5a);
    span(8'h00, 4, 2, 16'hffff);
    rchk("ovf count", A_CNT, after(16'hffff, 2, 16'h5a5a));
    rchk("ovf flag", A_CTL, 32'h80);
    wr(A_CNT, 32'h0);
    wr(A_CTL, 32'h06);
    k = $urandom_range(6, 2);
    repeat (k) u_tccr_pins.event_fall();
    wr(A_CTL, 32'h02);
    rchk("events", A_CNT, k);
    r = 16'($urandom());
    wr(A_CNT, {16'h0, r});
    wr(A_CTL, 32'h09);
    u_tccr_pins.trigger_fall();
    rchk("capture", A_CAP, r);
    rchk("ext flag", A_CTL, 32'h49);
    chk("ext irq", {31'h0, irq}, 32'h1);
    wr(A_CTL, 32'h01);
    wr(A_CNT, {16'h0, ~r});
    u_tccr_pins.trigger_fall();
    rchk("no capture", A_CAP, r);
    rchk("no flag", A_CTL, 32'h01);
    wr(A_CTL, 32'h08);
    u_tccr_pins.trigger_fall();
    rchk("reload", A_CNT, r);
    wr(A_CAP, 32'hfff0);
    wr(A_CNT, 32'hfff0);
    a0 = nrx; b0 = ntx;
    wr(A_CTL, 32'h35);
    repeat (1600) @(posedge ref_clk);
    wr(A_CTL, 32'h31);
    chk("rx baud", nrx - a0, 3);
    chk("tx baud", ntx - b0, 3);
    rchk("baud flag", A_CTL, 32'h31);
    wr(A_CTL, 32'h00);
    k = $urandom_range(6, 2);
    a0 = nrx; b0 = ntx;
    repeat (k) begin
      ovf <= 1'b1;
      @(posedge ref_clk);
      ovf <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    chk("rx other", nrx - a0, k);
    chk("tx other", ntx - b0, k);
    results();
  end
endmodule : tb_timer2_control_capture_reload
`default_nettype wire
